/* File: logic/flash_host.v */
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "flash_host_defs.vh"

module flash_host #(
  parameter PWRUP_CYCLES = `PWRUP_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        srst,
  input  wire        ce,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_r,
  output reg         pready_r,
  output reg         pslverr_r,
  // flash pins
  output reg         cs_n_r,
  output reg         sck_r,
  output reg         si_r,
  input  wire        so,
  output reg         wp_n_r,
  output reg         reset_n_r,
  input  wire        rdy_busy
);

  ////////////////////////////////////////////////////////////////////////
  // states
  localparam [5:0] S_PWR  = 6'h01;
  localparam [5:0] S_IDLE = 6'h02;
  localparam [5:0] S_HDR  = 6'h04;
  localparam [5:0] S_DATA = 6'h08;
  localparam [5:0] S_END  = 6'h10;
  localparam [5:0] S_GAP  = 6'h20;

  // array operation: needs the device ready first
  function is_array;
    input [7:0] op;
    begin
      case (op)
        `OP_PROG_BUF1, `OP_PROG_BUF2, `OP_XFER_BUF1, `OP_XFER_BUF2,
        `OP_COMP_BUF1, `OP_COMP_BUF2, `OP_REWR_BUF1, `OP_REWR_BUF2,
        `OP_ARRAY_RD, `OP_ARRAY_RD3, `OP_PAGE_RD, `OP_PAGE_RD3,
        `OP_PGM_E_BUF1, `OP_PGM_E_BUF2, `OP_PGM_BUF1, `OP_PGM_BUF2,
        `OP_PAGE_ERASE, `OP_BLOCK_ERASE: is_array = 1'b1;
        default: is_array = 1'b0;
      endcase
    end
  endfunction

  // commands that reprogram the addressed page
  function is_prog;
    input [7:0] op;
    begin
      case (op)
        `OP_PROG_BUF1, `OP_PROG_BUF2, `OP_REWR_BUF1, `OP_REWR_BUF2,
        `OP_PGM_E_BUF1, `OP_PGM_E_BUF2, `OP_PGM_BUF1, `OP_PGM_BUF2,
        `OP_PAGE_ERASE, `OP_BLOCK_ERASE: is_prog = 1'b1;
        default: is_prog = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg so_m_r, so_s_r, rb_m_r, rb_s_r;

  always @(posedge clk) begin
    if (srst) begin
      so_m_r <= 1'b0;
      so_s_r <= 1'b0;
      rb_m_r <= 1'b1;
      rb_s_r <= 1'b1;
    end else if (ce) begin
      so_m_r <= so;
      so_s_r <= so_m_r;
      rb_m_r <= rdy_busy;
      rb_s_r <= rb_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and state
  reg [5:0]  st_r;
  reg [7:0]  op_r;
  reg [23:0] addr_r;
  reg [8:0]  nbytes_r;
  reg [8:0]  cnt_r;
  reg [1:0]  hdr_r;
  reg [7:0]  wdata_r;
  reg        txr_r;
  reg [7:0]  rdata_r;
  reg        rxv_r;
  reg        wp_err_r;
  reg        flush_r;
  reg [2:0]  ctrl_r;
  reg [31:0] pwr_r;
  reg        pwr_done_r;
  reg        go_r;
  reg        is_rd_r;

  // shifter
  reg        sh_start_r;
  reg  [7:0] sh_tx_r;
  wire       sh_done;
  wire [7:0] sh_rx;
  wire       sh_sck;
  wire       sh_mosi;
  // shifter is idle between bytes
  reg        u_busy_r;
  wire       u_busy_n = ~u_busy_r & ~sh_start_r;

  spi_shift u_shift (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .cpol      (ctrl_r[`CTRL_CPOL_BIT]),
    .start     (sh_start_r),
    .tx_byte   (sh_tx_r),
    .done_r    (sh_done),
    .rx_byte_r (sh_rx),
    .sck_r     (sh_sck),
    .mosi_r    (sh_mosi),
    .miso_s    (so_s_r)
  );

  wire acc = psel & penable & ~pready_r;
  wire wr  = acc & pwrite;
  wire rd  = acc & ~pwrite;
  wire [11:0] page = addr_r[20:9];
  // pages below 256 are protected while write-protect is driven low
  wire prot_hit = is_prog(op_r) & ~ctrl_r[`CTRL_WP_BIT] & (page[11:8] == 4'h0);

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state
  always @(posedge clk) begin
    if (srst) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      pready_r  <= acc;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      if (acc) begin
        case (paddr)
          `REG_CMD:    prdata_r <= {24'h000000, op_r};
          `REG_ADDR:   prdata_r <= {8'h00, addr_r};
          `REG_RDATA:  prdata_r <= {24'h000000, rdata_r};
          `REG_BYTES:  prdata_r <= {23'h0, nbytes_r};
          `REG_CTRL:   prdata_r <= {29'h0, ctrl_r};
          // a command still waiting for the ready pin counts as busy
          `REG_STATUS: prdata_r <= {25'h0, flush_r, ~pwr_done_r, wp_err_r, rb_s_r, txr_r, rxv_r,
                                    ((st_r != S_IDLE) | go_r)};
          `REG_WDATA:  prdata_r <= {24'h000000, wdata_r};
          default:     pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @(posedge clk) begin
    if (srst) begin
      st_r       <= S_PWR;
      op_r       <= 8'h00;
      addr_r     <= 24'h000000;
      nbytes_r   <= 9'h000;
      cnt_r      <= 9'h000;
      hdr_r      <= 2'h0;
      wdata_r    <= 8'h00;
      txr_r      <= 1'b0;
      rdata_r    <= 8'h00;
      rxv_r      <= 1'b0;
      wp_err_r   <= 1'b0;
      flush_r    <= 1'b0;
      ctrl_r     <= `CTRL_RESET;
      pwr_r      <= 32'h0000_0000;
      pwr_done_r <= 1'b0;
      go_r       <= 1'b0;
      is_rd_r    <= 1'b0;
      sh_start_r <= 1'b0;
      sh_tx_r    <= 8'h00;
    end else if (ce) begin
      sh_start_r <= 1'b0;
      // register writes
      if (wr && paddr == `REG_ADDR) addr_r <= pwdata[23:0];
      if (wr && paddr == `REG_BYTES) nbytes_r <= pwdata[8:0];
      if (wr && paddr == `REG_CTRL) ctrl_r <= pwdata[2:0];
      if (wr && paddr == `REG_STATUS && pwdata[`ST_WPE_BIT]) wp_err_r <= 1'b0;
      if (wr && paddr == `REG_CMD && st_r == S_IDLE) begin
        op_r    <= pwdata[7:0];
        go_r    <= 1'b1;
        is_rd_r <= pwdata[8];
      end
      if (rd && paddr == `REG_RDATA) rxv_r <= 1'b0;
      case (st_r)
        S_PWR: begin
          pwr_r <= pwr_r + 32'h1;
          if (pwr_r >= PWRUP_CYCLES - 1) begin
            pwr_done_r <= 1'b1;
            st_r       <= S_IDLE;
          end
        end
        S_IDLE: begin
          // array commands wait for the ready pin before chip select falls
          if (go_r && ctrl_r[`CTRL_RST_BIT] && (!is_array(op_r) || rb_s_r)) begin
            go_r <= 1'b0;
            if (prot_hit) begin
              wp_err_r <= 1'b1;
            end else begin
              st_r       <= S_HDR;
              hdr_r      <= 2'h0;
              sh_tx_r    <= op_r;
              sh_start_r <= 1'b1;
            end
          end
        end
        S_HDR: begin
          // three address bytes follow the opcode for all but status read
          if (sh_done) begin
            if (op_r == `OP_STAT_RD || op_r == `OP_STAT_RD3 || hdr_r == 2'h3) begin
              st_r  <= (nbytes_r == 9'h000) ? S_END : S_DATA;
              cnt_r <= 9'h000;
              if (nbytes_r != 9'h000 && !is_rd_r) begin
                if (txr_r) begin
                  sh_tx_r    <= wdata_r;
                  txr_r      <= 1'b0;
                  sh_start_r <= 1'b1;
                end
              end else if (nbytes_r != 9'h000) begin
                sh_tx_r    <= 8'h00;
                sh_start_r <= 1'b1;
              end
            end else begin
              hdr_r      <= hdr_r + 2'h1;
              // reserved, page, offset
              sh_tx_r    <= (hdr_r == 2'h0) ? addr_r[23:16] : (hdr_r == 2'h1) ? addr_r[15:8] : addr_r[7:0];
              sh_start_r <= 1'b1;
            end
          end
        end
        S_DATA: begin
          // write bytes wait for software; read bytes after the first wait for rdata drained
          if (sh_done) begin
            cnt_r <= cnt_r + 9'h1;
            if (is_rd_r) begin
              rdata_r <= sh_rx;
              rxv_r   <= 1'b1;
              if (rxv_r) flush_r <= 1'b1;
            end
            if (cnt_r + 9'h1 == nbytes_r) st_r <= S_END;
          end else if (!sh_start_r && cnt_r != nbytes_r && !is_rd_r && txr_r && go_r == 1'b0 &&
                       u_busy_n && cnt_r != 9'h000) begin
            sh_tx_r    <= wdata_r;
            txr_r      <= 1'b0;
            sh_start_r <= 1'b1;
          end else if (!sh_start_r && cnt_r == 9'h000 && !is_rd_r && txr_r && u_busy_n) begin
            sh_tx_r    <= wdata_r;
            txr_r      <= 1'b0;
            sh_start_r <= 1'b1;
          end else if (!sh_start_r && is_rd_r && !rxv_r && u_busy_n && cnt_r != 9'h000) begin
            sh_tx_r    <= 8'h00;
            sh_start_r <= 1'b1;
          end
        end
        S_END: begin
          // chip select rise launches the self-timed operation in the device
          cnt_r <= 9'h000;
          st_r  <= S_GAP;
        end
        S_GAP: begin
          cnt_r <= cnt_r + 9'h1;
          if ({23'h0, cnt_r} == `CS_GAP_CYC) st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
      // a byte written while its predecessor is taken stays pending
      if (wr && paddr == `REG_WDATA) begin
        wdata_r <= pwdata[7:0];
        txr_r   <= 1'b1;
      end
    end
  end

  // shifter busy from its start until its done pulse
  always @(posedge clk) begin
    if (srst) u_busy_r <= 1'b0;
    else if (ce) begin
      if (sh_start_r) u_busy_r <= 1'b1;
      else if (sh_done) u_busy_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins
  always @(posedge clk) begin
    if (srst) begin
      cs_n_r    <= 1'b1;
      sck_r     <= 1'b1;
      si_r      <= 1'b0;
      wp_n_r    <= 1'b1;
      reset_n_r <= 1'b1;
    end else if (ce) begin
      // chip select low only across header and data
      cs_n_r    <= ~(st_r == S_HDR || st_r == S_DATA);
      // idle clock level sets the mode the device picks at select fall
      sck_r     <= sh_sck;
      si_r      <= sh_mosi;
      wp_n_r    <= ctrl_r[`CTRL_WP_BIT];
      reset_n_r <= ctrl_r[`CTRL_RST_BIT];
    end
  end

endmodule // flash_host

/* File: logic/flash_host_defs.vh */
`ifndef FLASH_HOST_DEFS_VH
`define FLASH_HOST_DEFS_VH

// register byte offsets on the apb side
`define REG_CMD        8'h00
`define REG_ADDR       8'h04
`define REG_WDATA      8'h08
`define REG_RDATA      8'h0C
`define REG_STATUS     8'h10
`define REG_CTRL       8'h14
`define REG_BYTES      8'h18

// status register fields
`define ST_BUSY_BIT    0
`define ST_RXV_BIT     1
`define ST_TXR_BIT     2
`define ST_RDY_BIT     3
`define ST_WPE_BIT     4
`define ST_PWR_BIT     5
`define ST_FLSH_BIT    6

// control register fields
`define CTRL_WP_BIT    0
`define CTRL_RST_BIT   1
`define CTRL_CPOL_BIT  2

// reset values
`define CTRL_RESET     3'h3

// device status bits
`define DEV_READY_BIT  7
`define DEV_COMP_BIT   6

// opcodes
`define OP_PROG_BUF1   8'h82
`define OP_PROG_BUF2   8'h85
`define OP_XFER_BUF1   8'h53
`define OP_XFER_BUF2   8'h55
`define OP_COMP_BUF1   8'h60
`define OP_COMP_BUF2   8'h61
`define OP_REWR_BUF1   8'h58
`define OP_REWR_BUF2   8'h59
`define OP_ARRAY_RD    8'h68
`define OP_ARRAY_RD3   8'hE8
`define OP_PAGE_RD     8'h52
`define OP_PAGE_RD3    8'hD2
`define OP_BUF1_RD     8'h54
`define OP_BUF1_RD3    8'hD4
`define OP_BUF2_RD     8'h56
`define OP_BUF2_RD3    8'hD6
`define OP_STAT_RD     8'h57
`define OP_STAT_RD3    8'hD7
`define OP_BUF1_WR     8'h84
`define OP_BUF2_WR     8'h87
`define OP_PGM_E_BUF1  8'h83
`define OP_PGM_E_BUF2  8'h86
`define OP_PGM_BUF1    8'h88
`define OP_PGM_BUF2    8'h89
`define OP_PAGE_ERASE  8'h81
`define OP_BLOCK_ERASE 8'h50

// timing
`define CLK_MHZ        100
`define PWRUP_MS       20
`define PWRUP_CYC      (`PWRUP_MS * 1000 * `CLK_MHZ)
`define SCK_HALF_CYC   4
`define CS_GAP_CYC     4
`define REWRITE_SPAN   10000

`endif

/* File: logic/spi_shift.v */
`timescale 1ns/1ps
`include "flash_host_defs.vh"

// one-byte shifter that makes the serial clock from clk by a divider
module spi_shift (
  // clock and reset
  input  wire       clk,
  input  wire       srst,
  input  wire       ce,
  // control
  input  wire       cpol,
  input  wire       start,
  input  wire [7:0] tx_byte,
  output reg        done_r,
  output reg  [7:0] rx_byte_r,
  // pins
  output reg        sck_r,
  output reg        mosi_r,
  input  wire       miso_s
);

  reg [2:0] div_r;
  reg [3:0] edge_r;
  reg [7:0] sh_r;
  reg       run_r;
  reg       pol_r;  // idle clock level latched for the whole byte

  // msb first, data set while clock low, sampled on rising edge
  always @(posedge clk) begin
    if (srst) begin
      div_r     <= 3'h0;
      edge_r    <= 4'h0;
      sh_r      <= 8'h00;
      run_r     <= 1'b0;
      pol_r     <= 1'b0;
      done_r    <= 1'b0;
      rx_byte_r <= 8'h00;
      sck_r     <= 1'b1;
      mosi_r    <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!run_r) begin
        sck_r <= cpol;
        if (start) begin
          run_r  <= 1'b1;
          pol_r  <= cpol;
          div_r  <= 3'h0;
          edge_r <= 4'h0;
          if (cpol) begin
            // idle-high clock: msb leaves on the first falling edge
            sh_r <= tx_byte;
          end else begin
            sh_r   <= {tx_byte[6:0], 1'b0};
            mosi_r <= tx_byte[7];
          end
        end
      end else if ({29'h0, div_r} == `SCK_HALF_CYC - 1) begin
        div_r  <= 3'h0;
        edge_r <= edge_r + 4'h1;
        if (edge_r[0] == pol_r) begin
          // rising edge: device samples input here
          sck_r     <= 1'b1;
          rx_byte_r <= {rx_byte_r[6:0], miso_s};
        end else begin
          // falling edge: device moves output, we move input
          sck_r  <= 1'b0;
          mosi_r <= sh_r[7];
          sh_r   <= {sh_r[6:0], 1'b0};
        end
        // sixteen half periods make one byte in either clock polarity
        if (edge_r == 4'hF) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end
      end else begin
        div_r <= div_r + 3'h1;
      end
    end
  end

endmodule // spi_shift

/* File: verif/flash_host_props.sv */
`timescale 1ns/1ps
`include "flash_host_defs.vh"
// pin and apb checks for the flash host
module flash_host_props #(
  parameter PWRUP_CYCLES = 10
) (
  // clock and reset
  input wire        clk,
  input wire        srst,
  input wire        ce,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata_r,
  input wire        pready_r,
  input wire        pslverr_r,
  // flash pins
  input wire        cs_n_r,
  input wire        sck_r,
  input wire        si_r,
  input wire        so,
  input wire        wp_n_r,
  input wire        reset_n_r,
  input wire        rdy_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  int unsigned up_r;
  logic [1:0]  ctl_r;
  // cycles since reset, saturating
  always @(posedge clk) begin
    if (srst) up_r <= 0;
    else if (up_r < PWRUP_CYCLES) up_r <= up_r + 1;
  end
  // last control word written
  always @(posedge clk) begin
    if (psel && penable && pwrite && pready_r && paddr == `REG_CTRL) ctl_r <= pwdata[1:0];
  end
  rst_pins_a: assert property ($fell(srst) |-> cs_n_r && wp_n_r && reset_n_r && !pready_r)
    else $error("pins not idle after reset");
  apb_wait_a: assert property (psel && penable && !pready_r && ce |=> pready_r)
    else $error("no answer one cycle after access");
  rdy_pulse_a: assert property (pready_r |=> !pready_r)
    else $error("ready longer than one cycle");
  err_qual_a: assert property (pslverr_r |-> pready_r)
    else $error("error without ready");
  si_hold_a: assert property (!cs_n_r && $past(!cs_n_r) && sck_r && $past(sck_r) |-> $stable(si_r))
    else $error("data changed while clock high");
  sck_half_a: assert property ($rose(sck_r) && !cs_n_r |-> sck_r[*4])
    else $error("clock high phase short");
  cs_gap_a: assert property ($rose(cs_n_r) |-> cs_n_r[*4])
    else $error("chip select gap short");
  ctrl_pin_a: assert property (psel && penable && pwrite && pready_r && paddr == `REG_CTRL
    |=> ##[0:1] {reset_n_r, wp_n_r} == ctl_r)
    else $error("pins do not follow control");
  pwr_wait_a: assert property ($fell(cs_n_r) |-> up_r >= PWRUP_CYCLES)
    else $error("frame before power-up wait");
  cover property ($fell(cs_n_r));
  cover property (pslverr_r);
  cover property (!rdy_busy && cs_n_r);
  cover property ($fell(cs_n_r) && sck_r);
endmodule // flash_host_props

bind flash_host flash_host_props #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_flash_host_props (
  .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
  .cs_n_r(cs_n_r), .sck_r(sck_r), .si_r(si_r), .so(so), .wp_n_r(wp_n_r),
  .reset_n_r(reset_n_r), .rdy_busy(rdy_busy));

/* File: verif/flash_dev_model.sv */
`timescale 1ns/1ps
// behavioural serial flash seen from its pins
module flash_dev_model #(
  parameter int BUSY_NS = 5000
) (
  // pins
  input  wire  cs_n,
  input  wire  sck,
  input  wire  si,
  input  wire  wp_n,
  input  wire  reset_n,
  output logic so,
  output wire  rdy_busy,
  // compare outcome to report
  input  wire  cmp_diff
);
  logic [31:0] sh_r;
  logic [7:0]  op_r, run_op, st;
  logic [23:0] addr_r;
  logic [7:0]  data0_r;
  logic        busy_r = 1'b0;
  logic        comp_r = 1'b0;
  logic        idle_hi_r;
  int          nbit, n_data, n_frame = 0, n_overlap = 0, n_wp_bad = 0, tok = 0;
  event        go;
  // ready/busy output, driven low while busy and driven high otherwise
  assign rdy_busy = busy_r ? 1'b0 : 1'b1;
  assign st = {!busy_r, comp_r, 6'h00};
  initial so = 1'b0;
  // frame start, idle clock level picks the mode
  always @(negedge cs_n) if (reset_n) begin
    nbit = 0;
    n_data = 0;
    idle_hi_r = sck;
  end
  // input taken on rising clock, msb first
  always @(posedge sck) if (!cs_n && reset_n) begin
    sh_r = {sh_r[30:0], si};
    nbit++;
    if (nbit == 8) op_r = sh_r[7:0];
    if (nbit == 32) addr_r = sh_r[23:0];
    if (nbit == 40) data0_r = sh_r[7:0];
    if (nbit > 32 && nbit % 8 == 0) n_data++;
  end
  // status leaves on falling clock, also while busy
  always @(negedge sck) if (!cs_n && nbit >= 8) so <= st[7 - (nbit - 8) % 8];
  // released line shows a changed level; array work starts at frame end
  always @(posedge cs_n) if (reset_n) begin
    so <= !so;
    n_frame++;
    if (nbit >= 32 && op_r inside {8'h52, 8'hD2, 8'h53, 8'h55, 8'h60, 8'h61, 8'h83, 8'h86,
        8'h88, 8'h89, 8'h81, 8'h50, 8'h82, 8'h85, 8'h58, 8'h59}) begin
      if (busy_r) n_overlap++;
      if (!wp_n && addr_r[20:9] < 256 && op_r inside {8'h82, 8'h85, 8'h83, 8'h86, 8'h88, 8'h89,
          8'h58, 8'h59}) n_wp_bad++;
      else begin
        run_op = op_r;
        ->go;
      end
    end
  end
  // self-timed operation
  always @(go) begin : run
    int t;
    tok++;
    t = tok;
    busy_r = 1'b1;
    #(BUSY_NS);
    if (t == tok) begin
      busy_r = 1'b0;
      if (run_op[7:1] == 7'h30) comp_r = cmp_diff;
    end
  end
  // reset low aborts the running operation
  always @(negedge reset_n) begin
    tok++;
    busy_r = 1'b0;
  end
endmodule // flash_dev_model

/* File: verif/flash_host_tb_top.sv */
`timescale 1ns/1ps
`include "flash_host_defs.vh"
// bench: apb master, device model, scenarios
module flash_host_tb_top;
  logic        clk = 1'b0, srst = 1'b1, ce = 1'b1, cmp_diff = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rde;
  logic [7:0]  paddr = 8'h00, rx;
  logic [31:0] pwdata = 32'h0, prdata_r, rdv;
  logic        pready_r, pslverr_r, cs_n_r, sck_r, si_r, so, wp_n_r, reset_n_r, rdy_busy;
  int          n_mismatch = 0, samples_checked = 0;
  // clock
  always #5 clk = ~clk;
  flash_host #(.PWRUP_CYCLES(40)) u_flash_host (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_r(prdata_r),
    .pready_r(pready_r), .pslverr_r(pslverr_r), .cs_n_r(cs_n_r), .sck_r(sck_r), .si_r(si_r),
    .so(so), .wp_n_r(wp_n_r), .reset_n_r(reset_n_r), .rdy_busy(rdy_busy));
  flash_dev_model dev (.cs_n(cs_n_r), .sck(sck_r), .si(si_r), .wp_n(wp_n_r),
    .reset_n(reset_n_r), .so(so), .rdy_busy(rdy_busy), .cmp_diff(cmp_diff));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the rising edge where pready is sampled high
    do begin
      @(posedge clk);
      n++;
    end while (pready_r !== 1'b1 && n < 100);
    if (pready_r !== 1'b1) n_mismatch++;
    rdv = prdata_r;
    rde = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wst(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      n++;
    end while (rdv[b] !== v && n < 2000);
    chk("status bit", rdv[b], v);
  endtask
  // one command with its data bytes
  task automatic cmd(input logic [8:0] op, input logic [23:0] ad, input int nb);
    apb(1'b1, `REG_BYTES, nb);
    apb(1'b1, `REG_ADDR, {8'h00, ad});
    apb(1'b1, `REG_CMD, {23'h0, op});
    for (int i = 0; i < nb; i++) begin
      if (op[8]) begin
        wst(`ST_RXV_BIT, 1'b1);
        apb(1'b0, `REG_RDATA, 32'h0);
        rx = rdv[7:0];
      end else begin
        apb(1'b1, `REG_WDATA, 32'hA0 + i);
        wst(`ST_TXR_BIT, 1'b0);
      end
    end
    wst(`ST_BUSY_BIT, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl", rdv[2:0], `CTRL_RESET);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", rde, 1'b1);
    wst(`ST_PWR_BIT, 1'b0);
  endtask
  task automatic t_prog;
    cmd(9'h082, 24'h0601FE, 3);
    chk("op", dev.op_r, 8'h82);
    chk("hdr", dev.addr_r, 24'h0601FE);
    chk("bytes", dev.n_data, 3);
    chk("data", dev.data0_r, 8'hA0);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("pin", rdv[`ST_RDY_BIT], 1'b0);
    cmd(9'h157, 24'h0, 1);
    chk("busy", rx, 8'h00);
    cmp_diff <= 1'b1;
    cmd(9'h061, 24'h060000, 0);
    chk("overlap", dev.n_overlap, 0);
    wst(`ST_RDY_BIT, 1'b1);
    cmd(9'h1D7, 24'h0, 1);
    chk("diff", rx, 8'hC0);
    cmp_diff <= 1'b0;
    cmd(9'h060, 24'h000200, 0);
    wst(`ST_RDY_BIT, 1'b1);
    cmd(9'h157, 24'h0, 1);
    chk("same", rx, 8'h80);
  endtask
  task automatic t_ops;
    logic [8:0] ops [20] = '{9'h053, 9'h055, 9'h058, 9'h059, 9'h081, 9'h050, 9'h083, 9'h086,
      9'h088, 9'h089, 9'h084, 9'h087, 9'h168, 9'h1E8, 9'h152, 9'h1D2, 9'h154, 9'h1D4, 9'h156, 9'h1D6};
    for (int i = 0; i < 20; i++) begin
      cmd(ops[i], 24'h02468A, ops[i][8]);
      chk("op", dev.op_r, ops[i][7:0]);
    end
  endtask
  task automatic t_wp;
    int f;
    apb(1'b1, `REG_CTRL, 32'h2);
    f = dev.n_frame;
    cmd(9'h083, 24'h01FE00, 0);
    chk("wp pin", wp_n_r, 1'b0);
    chk("frame", dev.n_frame, f);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("wp err", rdv[`ST_WPE_BIT], 1'b1);
    apb(1'b1, `REG_STATUS, 32'h10);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("wp clr", rdv[`ST_WPE_BIT], 1'b0);
    cmd(9'h083, 24'h020000, 0);
    chk("page 256", dev.n_frame, f + 1);
    chk("dev wp", dev.n_wp_bad, 0);
  endtask
  task automatic t_rst;
    apb(1'b1, `REG_CTRL, 32'h3);
    cmd(9'h086, 24'h040000, 0);
    apb(1'b1, `REG_CTRL, 32'h1);
    repeat (2) @(negedge clk);
    chk("rst pin", reset_n_r, 1'b0);
    chk("abort", dev.busy_r, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h7);
    cmd(9'h1D7, 24'h0, 1);
    chk("ready", rx, 8'h80);
    chk("mode", dev.idle_hi_r, 1'b1);
    chk("rewrite span", dev.n_frame < `REWRITE_SPAN, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_prog;
    t_ops;
    t_wp;
    t_rst;
    end_of_test;
  end
  // watchdog against a hung handshake
  initial begin
    #900000;
    n_mismatch++;
    end_of_test;
  end
endmodule // flash_host_tb_top
